// ===== verilog/aims_top.sv
// Top of the input mux select block: APB register file and decoded analog routing controls.
`timescale 1ns/1ns
`default_nettype none
module aims_top (
    // APB clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    // Analog switch controls
    output aims_pkg::aims_src_t pos_src,
    output aims_pkg::aims_src_t neg_src,
    output logic               differential,
    output logic [7:0]         pin_connect,
    output logic               even_group_active,
    output logic               odd_group_active,
    output logic [3:0]         hv_gain_field,
    output logic               hv_amp_enable
);
    aims_cfg_if cfg ();

    logic [3:0] channel_code;
    logic [7:0] pin_enable;
    logic [3:0] pair_config_reg;
    logic [3:0] hv_gain;
    logic       hv_enable;
    logic       access;
    logic       wr_en;
    logic       hit;
    logic [31:0] next_rdata;

    assign access = psel && penable;
    assign wr_en  = access && pwrite && pstrb[0];
    assign pready = 1'b1;

    // Address decode; an unmapped word reads zero and raises pslverr.
    always_comb begin
        hit        = 1'b1;
        next_rdata = 32'h0000_0000;
        if (paddr == aims_pkg::APB_CHANNEL_SELECT) begin
            next_rdata = {28'h000_0000, channel_code};
        end else if (paddr == aims_pkg::APB_PIN_ENABLE) begin
            next_rdata = {24'h00_0000, pin_enable};
        end else if (paddr == aims_pkg::APB_PAIR_CONFIG) begin
            next_rdata = {28'h000_0000, pair_config_reg};
        end else if (paddr == aims_pkg::APB_HV_CONTROL) begin
            next_rdata = {24'h00_0000, hv_enable, 3'h0, hv_gain};
        end else begin
            hit = 1'b0;
        end
    end

    // Zero-wait slave: read data is driven combinationally from the stored registers.
    assign prdata  = (access && !pwrite) ? next_rdata : 32'h0000_0000;
    assign pslverr = access && !hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_code <= aims_pkg::RESET_CHANNEL_SELECT[3:0];
        end else if (wr_en && paddr == aims_pkg::APB_CHANNEL_SELECT) begin
            channel_code <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_enable <= aims_pkg::RESET_PIN_ENABLE;
        end else if (wr_en && paddr == aims_pkg::APB_PIN_ENABLE) begin
            // Shared pins form a wired-OR; the hardware does not police it.
            pin_enable <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pair_config_reg <= aims_pkg::RESET_PAIR_CONFIG;
        end else if (wr_en && paddr == aims_pkg::APB_PAIR_CONFIG) begin
            pair_config_reg <= pwdata[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hv_gain   <= aims_pkg::RESET_HV_GAIN;
            hv_enable <= 1'b0;
        end else if (wr_en && paddr == aims_pkg::APB_HV_CONTROL) begin
            hv_gain   <= pwdata[3:0];
            hv_enable <= pwdata[aims_pkg::HV_ENABLE_BIT];
        end
    end

    assign cfg.channel_code = channel_code;
    assign cfg.pin_enable   = pin_enable;
    assign cfg.pair_config  = pair_config_reg;
    assign cfg.hv_gain      = hv_gain;
    assign cfg.hv_enable    = hv_enable;
    assign hv_gain_field    = hv_gain;
    assign hv_amp_enable    = hv_enable;

    aims_route u_route (
        .pclk              (pclk),
        .presetn           (presetn),
        .cfg               (cfg),
        .pos_src           (pos_src),
        .neg_src           (neg_src),
        .differential      (differential),
        .pin_connect       (pin_connect),
        .even_group_active (even_group_active),
        .odd_group_active  (odd_group_active)
    );
endmodule
`default_nettype wire

// ===== verilog/aims_pkg.sv
// Package with register map, field layouts and source codes of the input mux select block.
`default_nettype none
package aims_pkg;
    // Register indexes; each register takes one aligned 32-bit word.
    localparam logic [7:0] ADDR_CHANNEL_SELECT = 8'hBB;
    localparam logic [7:0] ADDR_PIN_ENABLE     = 8'hBD;
    localparam logic [7:0] ADDR_PAIR_CONFIG    = 8'hBA;
    localparam logic [7:0] ADDR_HV_CONTROL     = 8'hD6;
    // Byte addresses used on APB (register index times four).
    localparam logic [11:0] APB_CHANNEL_SELECT = 12'h2EC;
    localparam logic [11:0] APB_PIN_ENABLE     = 12'h2F4;
    localparam logic [11:0] APB_PAIR_CONFIG    = 12'h2E8;
    localparam logic [11:0] APB_HV_CONTROL     = 12'h358;

    localparam logic [7:0] RESET_CHANNEL_SELECT = 8'h00;
    localparam logic [7:0] RESET_PIN_ENABLE     = 8'h00;
    localparam logic [3:0] RESET_PAIR_CONFIG    = 4'h0;
    localparam logic [3:0] RESET_HV_GAIN        = 4'h0;

    // Pair configuration bit positions, then the enable bit position of the HV control register.
    localparam int PAIR_AIN01  = 0;
    localparam int PAIR_AIN23  = 1;
    localparam int PAIR_HV     = 2;
    localparam int PAIR_PORT3  = 3;
    localparam int HV_ENABLE_BIT = 7;

    // Channel codes.
    localparam logic [3:0] CODE_EXT0  = 4'h0;
    localparam logic [3:0] CODE_EXT1  = 4'h1;
    localparam logic [3:0] CODE_EXT2  = 4'h2;
    localparam logic [3:0] CODE_EXT3  = 4'h3;
    localparam logic [3:0] CODE_HV    = 4'h4;
    localparam logic [3:0] CODE_AGND  = 4'h5;
    localparam logic [3:0] CODE_P3EV  = 4'h6;
    localparam logic [3:0] CODE_P3OD  = 4'h7;

    // Analog source identifiers presented to the switch matrix.
    typedef enum logic [3:0] {
        SRC_NONE,
        SRC_EXT0,
        SRC_EXT1,
        SRC_EXT2,
        SRC_EXT3,
        SRC_HV_AMP,
        SRC_AGND,
        SRC_P3_EVEN,
        SRC_P3_ODD,
        SRC_TEMP,
        SRC_HV_REF
    } aims_src_t;
endpackage
`default_nettype wire

// ===== verilog/aims_cfg_if.sv
// Interface carrying the stored configuration from the register file to the route decoder.
`timescale 1ns/1ns
`default_nettype none
interface aims_cfg_if;
    logic [3:0] channel_code;
    logic [3:0] pair_config;
    logic [7:0] pin_enable;
    logic [3:0] hv_gain;
    logic       hv_enable;
    modport regs (output channel_code, output pair_config, output pin_enable, output hv_gain, output hv_enable);
    modport route (input channel_code, input pair_config, input pin_enable, input hv_gain, input hv_enable);
endinterface
`default_nettype wire

// ===== verilog/aims_route.sv
// Decoder from channel code and pair configuration to the positive and negative mux sources.
`timescale 1ns/1ns
`default_nettype none
module aims_route (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Stored configuration
    aims_cfg_if.route         cfg,
    // Decoded selection
    output aims_pkg::aims_src_t pos_src,
    output aims_pkg::aims_src_t neg_src,
    output logic              differential,
    output logic [7:0]        pin_connect,
    output logic              even_group_active,
    output logic              odd_group_active
);
    aims_pkg::aims_src_t next_pos;
    aims_pkg::aims_src_t next_neg;
    logic                next_diff;
    logic [7:0]          next_pins;

    always_comb begin
        next_pos  = aims_pkg::SRC_NONE;
        next_neg  = aims_pkg::SRC_AGND;
        next_diff = 1'b0;
        if (cfg.channel_code[3]) begin
            next_pos = aims_pkg::SRC_TEMP;
        end else begin
            case (cfg.channel_code)
                aims_pkg::CODE_EXT0: begin
                    next_pos = aims_pkg::SRC_EXT0;
                    if (cfg.pair_config[aims_pkg::PAIR_AIN01]) begin
                        next_neg  = aims_pkg::SRC_EXT1;
                        next_diff = 1'b1;
                    end
                end
                aims_pkg::CODE_EXT1: begin
                    // Odd member of a differential pair selects nothing.
                    next_pos = cfg.pair_config[aims_pkg::PAIR_AIN01] ? aims_pkg::SRC_NONE
                                                                     : aims_pkg::SRC_EXT1;
                end
                aims_pkg::CODE_EXT2: begin
                    next_pos = aims_pkg::SRC_EXT2;
                    if (cfg.pair_config[aims_pkg::PAIR_AIN23]) begin
                        next_neg  = aims_pkg::SRC_EXT3;
                        next_diff = 1'b1;
                    end
                end
                aims_pkg::CODE_EXT3: begin
                    next_pos = cfg.pair_config[aims_pkg::PAIR_AIN23] ? aims_pkg::SRC_NONE
                                                                     : aims_pkg::SRC_EXT3;
                end
                aims_pkg::CODE_HV: begin
                    next_pos = aims_pkg::SRC_HV_AMP;
                    if (cfg.pair_config[aims_pkg::PAIR_HV]) begin
                        next_neg  = aims_pkg::SRC_HV_REF;
                        next_diff = 1'b1;
                    end
                end
                aims_pkg::CODE_AGND: begin
                    next_pos = cfg.pair_config[aims_pkg::PAIR_HV] ? aims_pkg::SRC_NONE
                                                                  : aims_pkg::SRC_AGND;
                end
                aims_pkg::CODE_P3EV: begin
                    next_pos = aims_pkg::SRC_P3_EVEN;
                    if (cfg.pair_config[aims_pkg::PAIR_PORT3]) begin
                        next_neg  = aims_pkg::SRC_P3_ODD;
                        next_diff = 1'b1;
                    end
                end
                default: begin
                    next_pos = cfg.pair_config[aims_pkg::PAIR_PORT3] ? aims_pkg::SRC_NONE
                                                                     : aims_pkg::SRC_P3_ODD;
                end
            endcase
        end
    end

    // Each pin switch follows its own enable bit; any mix is allowed.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            assign next_pins[g] = cfg.pin_enable[g];
        end
    endgenerate

    // Outputs are registered so the analog switches see glitch-free controls.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_src      <= aims_pkg::SRC_EXT0;
            neg_src      <= aims_pkg::SRC_AGND;
            differential <= 1'b0;
            pin_connect  <= 8'h00;
        end else begin
            pos_src      <= next_pos;
            neg_src      <= next_neg;
            differential <= next_diff;
            pin_connect  <= next_pins;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            even_group_active <= 1'b0;
            odd_group_active  <= 1'b0;
        end else begin
            // Even pins share one mux input, odd pins the other.
            even_group_active <= |{next_pins[6], next_pins[4], next_pins[2], next_pins[0]};
            odd_group_active  <= |{next_pins[7], next_pins[5], next_pins[3], next_pins[1]};
        end
    end
endmodule
`default_nettype wire

// ===== sim/aims_top_assertions.sv
// Concurrent checks on the ports of the input mux select block.
`timescale 1ns/1ns
`default_nettype none
module aims_top_assertions (
    // APB side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Routing controls
    input var aims_pkg::aims_src_t pos_src,
    input var aims_pkg::aims_src_t neg_src,
    input wire logic        differential,
    input wire logic [7:0]  pin_connect,
    input wire logic        even_group_active,
    input wire logic        odd_group_active
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic mapped = paddr inside {aims_pkg::APB_CHANNEL_SELECT, aims_pkg::APB_PIN_ENABLE,
                                      aims_pkg::APB_PAIR_CONFIG, aims_pkg::APB_HV_CONTROL};
    sequence s_ch_wr;
        psel && penable && pwrite && pstrb[0] && paddr == aims_pkg::APB_CHANNEL_SELECT;
    endsequence
    sequence s_temp_wr;
        s_ch_wr ##0 pwdata[3];
    endsequence
    a_upper_read_zero: assert property (psel && penable && !pwrite && paddr == aims_pkg::APB_CHANNEL_SELECT
        |-> prdata[31:4] == 28'h0) else $error("channel select upper bits not zero");
    a_unmapped_err: assert property (psel && penable && !mapped
        |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
    a_temp_route: assert property (s_temp_wr |-> ##2 pos_src == aims_pkg::SRC_TEMP)
        else $error("temperature code not routed");
    a_single_gnd: assert property (!differential |-> neg_src == aims_pkg::SRC_AGND)
        else $error("single-ended negative not ground");
    a_pair_neg: assert property (differential && pos_src == aims_pkg::SRC_EXT0
        |-> neg_src == aims_pkg::SRC_EXT1) else $error("input pair negative wrong");
    a_hv_ref_neg: assert property (differential && pos_src == aims_pkg::SRC_HV_AMP
        |-> neg_src == aims_pkg::SRC_HV_REF) else $error("amplifier reference not on negative");
    a_even_group: assert property (even_group_active == |(pin_connect & 8'h55))
        else $error("even group flag wrong");
    a_odd_group: assert property (odd_group_active == |(pin_connect & 8'hAA))
        else $error("odd group flag wrong");
    a_reset_state: assert property ($rose(presetn) |-> pos_src == aims_pkg::SRC_EXT0 && pin_connect == 8'h00)
        else $error("state after reset wrong");
endmodule
bind aims_top aims_top_assertions u_aims_top_assertions (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pslverr, .pos_src, .neg_src, .differential, .pin_connect, .even_group_active,
    .odd_group_active);
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the input mux select block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0]  pstrb = 4'h0, hv_gain_field;
    logic        pready, pslverr, rerr, differential, even_group_active, odd_group_active, hv_amp_enable;
    logic [7:0]  pin_connect;
    aims_pkg::aims_src_t pos_src, neg_src;
    int          miscompares = 0, n_checks = 0, cyc = 0;
    aims_pkg::aims_src_t se[8] = '{aims_pkg::SRC_EXT0, aims_pkg::SRC_EXT1, aims_pkg::SRC_EXT2, aims_pkg::SRC_EXT3,
        aims_pkg::SRC_HV_AMP, aims_pkg::SRC_AGND, aims_pkg::SRC_P3_EVEN, aims_pkg::SRC_P3_ODD};
    aims_pkg::aims_src_t pn[4] = '{aims_pkg::SRC_EXT1, aims_pkg::SRC_EXT3, aims_pkg::SRC_HV_REF, aims_pkg::SRC_P3_ODD};
    logic [7:0]  pins[7] = '{8'h01, 8'h80, 8'hAA, 8'h55, 8'hFF, 8'h00, 8'h3C};
    always #4 pclk = ~pclk;
    aims_top u_aims_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .pos_src, .neg_src, .differential, .pin_connect, .even_group_active, .odd_group_active,
        .hv_gain_field, .hv_amp_enable);
    task automatic conclude();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0, 4'h0);
    endtask
    // Decoded outputs follow one edge after the write, so two edges are allowed.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
        repeat (2) @(posedge pclk);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic t_reset_state();
        rd(aims_pkg::APB_CHANNEL_SELECT);
        chk(rdat, 32'h0);
        rd(aims_pkg::APB_PIN_ENABLE);
        chk(rdat, 32'h0);
        chk({pos_src, neg_src, pin_connect}, {aims_pkg::SRC_EXT0, aims_pkg::SRC_AGND, 8'h00});
        chk(pready, 1'b1);
    endtask
    task automatic t_channel();
        wr(aims_pkg::APB_CHANNEL_SELECT, 32'hFFFF_FFFF);
        rd(aims_pkg::APB_CHANNEL_SELECT);
        chk(rdat, 32'h0000_000F);
        apb(1'b1, aims_pkg::APB_CHANNEL_SELECT, 32'h3, 4'hE);
        rd(aims_pkg::APB_CHANNEL_SELECT);
        chk(rdat, 32'h0000_000F);
        apb(1'b1, 12'h000, 32'hFF, 4'hF);
        chk(rerr, 1'b1);
        rd(12'h2F0);
        chk({rerr, rdat}, {1'b1, 32'h0});
        rd(aims_pkg::APB_PIN_ENABLE);
        chk({rerr, rdat}, {1'b0, 32'h0});
    endtask
    task automatic t_single();
        for (int c = 0; c < 16; c++) begin
            wr(aims_pkg::APB_CHANNEL_SELECT, 32'(c));
            chk(pos_src, c > 7 ? aims_pkg::SRC_TEMP : se[c % 8]);
            chk({neg_src, differential}, {aims_pkg::SRC_AGND, 1'b0});
        end
    endtask
    // Each pair bit alone: its even code pairs, its odd code is empty, the next pair stays single.
    task automatic t_pairs();
        for (int k = 0; k < 4; k++) begin
            wr(aims_pkg::APB_PAIR_CONFIG, 32'(1 << k));
            wr(aims_pkg::APB_CHANNEL_SELECT, 32'(2 * k));
            chk({pos_src, neg_src, differential}, {se[2 * k], pn[k], 1'b1});
            wr(aims_pkg::APB_CHANNEL_SELECT, 32'(2 * k + 1));
            chk({pos_src, neg_src}, {aims_pkg::SRC_NONE, aims_pkg::SRC_AGND});
            wr(aims_pkg::APB_CHANNEL_SELECT, 32'((2 * k + 2) % 8));
            chk({pos_src, neg_src}, {se[(2 * k + 2) % 8], aims_pkg::SRC_AGND});
        end
        wr(aims_pkg::APB_PAIR_CONFIG, 32'h0);
    endtask
    task automatic t_pins();
        foreach (pins[i]) begin
            wr(aims_pkg::APB_PIN_ENABLE, {24'h0, pins[i]});
            rd(aims_pkg::APB_PIN_ENABLE);
            chk(rdat, {24'h0, pins[i]});
            chk(pin_connect, pins[i]);
            chk({even_group_active, odd_group_active}, {|(pins[i] & 8'h55), |(pins[i] & 8'hAA)});
        end
    endtask
    task automatic t_hv();
        for (int g = 0; g < 16; g++) begin
            wr(aims_pkg::APB_HV_CONTROL, {24'h0, g[0], 3'h0, g[3:0]});
            chk({hv_amp_enable, hv_gain_field}, {g[0], g[3:0]});
        end
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        do_reset();
        t_reset_state();
        t_channel();
        t_single();
        t_pairs();
        t_pins();
        t_hv();
        do_reset();
        t_reset_state();
        conclude();
    end
endmodule
`default_nettype wire
